// [include/usart_aux_defines.vh]
/*
 * constants for the serial transceiver auxiliary block: frame sizes,
 * timing counts and the address-mark bit position.
 * assumes a 125 MHz system clock and a baud tick supplied by the core.
 */
// Operation
// - mute suppresses receive flags and interrupts
// - mute exit follows the wake method setting
// - idle frame clears mute request bit
// - address byte low four bits compared
// - mismatch mutes, match unmutes receiver
// - clock output enable selects synchronous master
// - no clock during start or stop
// - last bit pulse enable gates final pulse
// - polarity sets idle level, phase sets edge
// - clock inactive when idle or break
// - start frame only with data, cts low
// - cts rise finishes frame then holds
// - rts low while able, high after frame
// - driver enable output around transmissions
// - de asserted lead time before start
// - de held lag time after stop
// - dma transmit requests fill transmit data
// - one dma receive request per byte
// - individual interrupt enables per source
// - enabled interrupt sources ored together
// - wake method zero idle, one address
`ifndef USART_AUX_DEFINES_VH
`define USART_AUX_DEFINES_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DATA_BITS 4'd8
`define ADDR_MARK_BIT 7
`define ADDR_BITS 4
// character time: start + 8 data + 1 stop, in baud ticks
`define CHAR_TICKS 4'd10

// ----------------------------------------------------------------
// transmit states
// ----------------------------------------------------------------
`define TX_IDLE 3'd0
`define TX_LEAD 3'd1
`define TX_START 3'd2
`define TX_DATA 3'd3
`define TX_STOP 3'd4
`define TX_LAG 3'd5
`define TX_BREAK 3'd6

`endif

// [rtl/usart_aux.v]
/*
 * transmit/receive auxiliary logic: mute handling, synchronous clock
 * output, cts/rts flow control, driver enable, dma requests and irq merge.
 * assumes baud_tick_i is a one-cycle pulse per bit time from a divider
 * on the same clock; rx pin and cts pin are asynchronous.
 */
`include "usart_aux_defines.vh"

// ----------------------------------------------------------------
// two-entry skid buffer for transmit data
// ----------------------------------------------------------------
module tx_skid_buf
(
	input wire clk_sys_i, // system clock
	input wire arst_n_i, // async reset, low
	input wire [7:0] in_data_i, // word from source
	input wire in_valid_i, // source word valid
	output wire in_ready_o, // buffer can take word
	output wire [7:0] out_data_o, // word to shifter
	output wire out_valid_o, // buffer holds a word
	input wire out_ready_i // shifter takes word
);
	reg [7:0] mem_ff [0:1];
	reg wr_ptr_ff;
	reg rd_ptr_ff;
	reg [1:0] cnt_ff;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_ff != 2'd2);
	assign out_valid_o = (cnt_ff != 2'd0);
	assign out_data_o = mem_ff[rd_ptr_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// pointer and count update; storage needs no reset
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff <= 2'd0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= ~wr_ptr_ff;
			if (pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	always @(posedge clk_sys_i)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data_i;
	end
endmodule // tx_skid_buf

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module usart_aux
(
	input wire clk_sys_i, // system clock
	input wire arst_n_i, // async reset, low
	input wire baud_tick_i, // one pulse per bit time
	input wire rx_pin_i, // serial receive line
	input wire cts_n_pin_i, // clear to send, low
	input wire [7:0] tx_wdata_i, // transmit data write
	input wire tx_wvalid_i, // transmit data strobe
	output reg tx_wready_o, // transmit buffer can take data
	input wire [7:0] rx_byte_i, // byte from receive shifter
	input wire rx_byte_valid_i, // byte received pulse
	input wire rx_parity_err_i, // parity error on byte
	input wire rx_noise_err_i, // noise on byte
	input wire rx_frame_err_i, // frame error on byte
	input wire rx_char_match_i, // character match pulse
	input wire rx_timeout_i, // receive timeout pulse
	input wire rx_data_read_i, // rx data consumed
	input wire tx_send_break_i, // send break frame
	input wire mute_request_set_i, // sw sets mute request
	input wire mute_request_clr_i, // sw clears mute request
	input wire wake_method_select_i, // 0 idle, 1 address
	input wire [3:0] node_address_i, // own node address
	input wire half_duplex_enable_i, // must be 0 in sync mode
	input wire clock_output_enable_i, // sync mode select
	input wire last_bit_clock_pulse_enable_i, // pulse on last bit
	input wire clock_polarity_i, // idle level of clock
	input wire clock_phase_i, // capture edge select
	input wire cts_flow_enable_i, // cts flow control on
	input wire rts_flow_enable_i, // rts flow control on
	input wire driver_enable_function_i, // de output on
	input wire [4:0] de_lead_time_i, // de lead in bit times
	input wire [4:0] de_lag_time_i, // de lag in bit times
	input wire dma_transmit_enable_i, // dma tx requests on
	input wire dma_receive_enable_i, // dma rx requests on
	input wire flag_clr_i, // clears all sticky flags
	input wire rx_not_empty_irq_en_i, // rx not empty / overrun
	input wire idle_irq_en_i, // idle line
	input wire parity_irq_en_i, // parity error
	input wire error_irq_en_i, // dma mode errors
	input wire char_match_irq_en_i, // character match
	input wire timeout_irq_en_i, // receive timeout
	input wire tx_empty_irq_en_i, // transmit empty
	input wire tx_complete_irq_en_i, // transmit complete
	input wire cts_irq_en_i, // cts change
	output reg tx_pin_o, // serial transmit line
	output reg sync_clock_out_o, // synchronous clock
	output reg rts_n_o, // request to send, low
	output reg de_o, // driver enable
	output reg dma_tx_req_o, // dma transmit request
	output reg dma_rx_req_o, // dma receive request
	output reg mute_request_o, // mute state
	output reg rx_not_empty_flag_o, // status
	output reg overrun_flag_o, // status
	output reg idle_line_flag_o, // status
	output reg parity_error_flag_o, // status
	output reg noise_error_flag_o, // status
	output reg framing_error_flag_o, // status
	output reg char_match_flag_o, // status
	output reg timeout_flag_o, // status
	output reg tx_empty_flag_o, // status
	output reg tx_complete_flag_o, // status
	output reg cts_change_flag_o, // status
	output reg irq_o // merged interrupt
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg rx_meta_ff, rx_sync_ff, cts_meta_ff, cts_sync_ff, cts_prev_ff;
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			cts_meta_ff <= 1'b1;
			cts_sync_ff <= 1'b1;
			cts_prev_ff <= 1'b1;
		end
		else
		begin
			rx_meta_ff <= rx_pin_i;
			rx_sync_ff <= rx_meta_ff;
			cts_meta_ff <= cts_n_pin_i;
			cts_sync_ff <= cts_meta_ff;
			cts_prev_ff <= cts_sync_ff;
		end
	end

	// ----------------------------------------------------------------
	// idle detect and mute
	// ----------------------------------------------------------------
	reg [3:0] idle_cnt_ff;
	reg idle_seen_ff;
	wire idle_hit = baud_tick_i & rx_sync_ff & (idle_cnt_ff == `CHAR_TICKS - 4'd1) & ~idle_seen_ff;
	wire is_addr = rx_byte_valid_i & wake_method_select_i & rx_byte_i[`ADDR_MARK_BIT];
	wire addr_match = (rx_byte_i[`ADDR_BITS-1:0] == node_address_i);
	// the address byte itself is never delivered while it decides mute
	wire rx_live = rx_byte_valid_i & ~mute_request_o & ~is_addr;

	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			idle_cnt_ff <= 4'd0;
			idle_seen_ff <= 1'b0;
			mute_request_o <= 1'b0;
		end
		else
		begin
			if (!rx_sync_ff)
			begin
				idle_cnt_ff <= 4'd0;
				idle_seen_ff <= 1'b0;
			end
			else if (idle_hit)
				idle_seen_ff <= 1'b1; // one idle event per high stretch
			else if (baud_tick_i && !idle_seen_ff)
				idle_cnt_ff <= idle_cnt_ff + 4'd1;
			// hardware wake beats software set in same cycle
			if (is_addr)
				mute_request_o <= ~addr_match;
			else if (idle_hit && !wake_method_select_i)
				mute_request_o <= 1'b0;
			else if (mute_request_clr_i)
				mute_request_o <= 1'b0;
			else if (mute_request_set_i)
				mute_request_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// transmit buffer and shifter
	// ----------------------------------------------------------------
	wire buf_in_ready, buf_valid;
	wire [7:0] buf_data;
	reg tx_take;
	tx_skid_buf u_buf
	(
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.in_data_i(tx_wdata_i),
		.in_valid_i(tx_wvalid_i),
		.in_ready_o(buf_in_ready),
		.out_data_o(buf_data),
		.out_valid_o(buf_valid),
		.out_ready_i(tx_take)
	);

	reg [2:0] st_ff;
	reg [7:0] shift_ff;
	reg [4:0] cnt_ff;
	reg half_ff;
	wire cts_ok = ~cts_flow_enable_i | ~cts_sync_ff; // sampled only between frames
	wire sync_on = clock_output_enable_i & ~half_duplex_enable_i;
	wire last_bit = (cnt_ff == 5'd7);

	always @*
	begin
		tx_take = 1'b0;
		if (baud_tick_i && buf_valid && cts_ok && !tx_send_break_i)
			tx_take = (st_ff == `TX_IDLE && (!driver_enable_function_i || de_lead_time_i == 5'd0))
				|| (st_ff == `TX_LEAD && cnt_ff == 5'd0) || (st_ff == `TX_STOP);
	end

	// frame sequencer; lead/lag counted in bit times
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_ff <= `TX_IDLE;
			shift_ff <= 8'h00;
			cnt_ff <= 5'd0;
			half_ff <= 1'b0;
			tx_pin_o <= 1'b1;
			de_o <= 1'b0;
			sync_clock_out_o <= 1'b0;
		end
		else
		begin
			sync_clock_out_o <= clock_polarity_i; // idle level by default
			case (st_ff)
				`TX_IDLE:
				begin
					tx_pin_o <= 1'b1;
					de_o <= 1'b0;
					if (tx_send_break_i && baud_tick_i)
					begin
						st_ff <= `TX_BREAK;
						cnt_ff <= 5'd0;
					end
					else if (tx_take)
					begin
						shift_ff <= buf_data;
						st_ff <= `TX_START;
						tx_pin_o <= 1'b0;
						de_o <= driver_enable_function_i;
					end
					else if (baud_tick_i && buf_valid && cts_ok && driver_enable_function_i)
					begin
						st_ff <= `TX_LEAD;
						cnt_ff <= de_lead_time_i - 5'd1;
						de_o <= 1'b1;
					end
				end
				`TX_LEAD:
				if (tx_take)
				begin
					shift_ff <= buf_data;
					st_ff <= `TX_START;
					tx_pin_o <= 1'b0;
				end
				else if (baud_tick_i && cnt_ff != 5'd0)
					cnt_ff <= cnt_ff - 5'd1;
				`TX_START:
				if (baud_tick_i)
				begin
					st_ff <= `TX_DATA;
					cnt_ff <= 5'd0;
					half_ff <= 1'b0;
					tx_pin_o <= shift_ff[0];
				end
				`TX_DATA:
				begin
					// first cycle after tick only: phase 0 holds idle level, edge one cycle into the bit
					if (sync_on && (!last_bit || last_bit_clock_pulse_enable_i))
						sync_clock_out_o <= clock_polarity_i ^ (half_ff ^ clock_phase_i);
					if (baud_tick_i)
					begin
						half_ff <= 1'b0;
						shift_ff <= {1'b0, shift_ff[7:1]};
						if (last_bit)
						begin
							st_ff <= `TX_STOP;
							tx_pin_o <= 1'b1;
						end
						else
						begin
							cnt_ff <= cnt_ff + 5'd1;
							tx_pin_o <= shift_ff[1];
						end
					end
					else
						half_ff <= 1'b1;
				end
				`TX_STOP:
				if (baud_tick_i)
				begin
					if (tx_take)
					begin
						// back to back frame keeps de up, no lag
						shift_ff <= buf_data;
						st_ff <= `TX_START;
						tx_pin_o <= 1'b0;
					end
					else if (driver_enable_function_i && de_lag_time_i != 5'd0)
					begin
						st_ff <= `TX_LAG;
						cnt_ff <= de_lag_time_i;
					end
					else
					begin
						st_ff <= `TX_IDLE;
						de_o <= 1'b0;
					end
				end
				`TX_LAG:
				if (baud_tick_i)
				begin
					if (cnt_ff == 5'd1)
					begin
						st_ff <= `TX_IDLE;
						de_o <= 1'b0;
					end
					cnt_ff <= cnt_ff - 5'd1;
				end
				`TX_BREAK:
				begin
					tx_pin_o <= 1'b0; // no clock during break
					if (baud_tick_i)
					begin
						cnt_ff <= cnt_ff + 5'd1;
						if (cnt_ff == {1'b0, `CHAR_TICKS} - 5'd1)
						begin
							st_ff <= `TX_IDLE;
							tx_pin_o <= 1'b1;
						end
					end
				end
				default:
					st_ff <= `TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flags, rts, dma
	// ----------------------------------------------------------------
	wire tx_done = (st_ff == `TX_STOP) & baud_tick_i & ~tx_take;
	wire rx_read = rx_data_read_i | dma_rx_req_o;
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rx_not_empty_flag_o <= 1'b0;
			overrun_flag_o <= 1'b0;
			idle_line_flag_o <= 1'b0;
			parity_error_flag_o <= 1'b0;
			noise_error_flag_o <= 1'b0;
			framing_error_flag_o <= 1'b0;
			char_match_flag_o <= 1'b0;
			timeout_flag_o <= 1'b0;
			tx_empty_flag_o <= 1'b1;
			tx_complete_flag_o <= 1'b1;
			cts_change_flag_o <= 1'b0;
			rts_n_o <= 1'b1;
			dma_tx_req_o <= 1'b0;
			dma_rx_req_o <= 1'b0;
			tx_wready_o <= 1'b0;
			irq_o <= 1'b0;
		end
		else
		begin
			// every set term wins over clear in the same cycle
			rx_not_empty_flag_o <= rx_live | (rx_not_empty_flag_o & ~rx_read & ~flag_clr_i);
			overrun_flag_o <= (rx_live & rx_not_empty_flag_o & ~rx_read) | (overrun_flag_o & ~flag_clr_i);
			idle_line_flag_o <= (idle_hit & ~mute_request_o) | (idle_line_flag_o & ~flag_clr_i);
			parity_error_flag_o <= (rx_live & rx_parity_err_i) | (parity_error_flag_o & ~flag_clr_i);
			noise_error_flag_o <= (rx_live & rx_noise_err_i) | (noise_error_flag_o & ~flag_clr_i);
			framing_error_flag_o <= (rx_live & rx_frame_err_i) | (framing_error_flag_o & ~flag_clr_i);
			char_match_flag_o <= (rx_char_match_i & ~mute_request_o) | (char_match_flag_o & ~flag_clr_i);
			timeout_flag_o <= (rx_timeout_i & ~mute_request_o) | (timeout_flag_o & ~flag_clr_i);
			tx_empty_flag_o <= ~buf_valid;
			tx_complete_flag_o <= tx_done | (tx_complete_flag_o & ~flag_clr_i & ~tx_take);
			cts_change_flag_o <= (cts_flow_enable_i & (cts_sync_ff ^ cts_prev_ff)) | (cts_change_flag_o & ~flag_clr_i);
			// rts high from byte arrival until data consumed
			rts_n_o <= rts_flow_enable_i & (rx_live | (rx_not_empty_flag_o & ~rx_read));
			dma_tx_req_o <= dma_transmit_enable_i & buf_in_ready & ~tx_wvalid_i;
			dma_rx_req_o <= dma_receive_enable_i & rx_live; // one pulse per byte
			tx_wready_o <= buf_in_ready;
			// merge enabled sources onto one line
			irq_o <= (rx_not_empty_irq_en_i & (rx_not_empty_flag_o | overrun_flag_o))
				| (idle_irq_en_i & idle_line_flag_o)
				| (parity_irq_en_i & parity_error_flag_o)
				| (error_irq_en_i & dma_receive_enable_i
					& (noise_error_flag_o | overrun_flag_o | framing_error_flag_o))
				| (char_match_irq_en_i & char_match_flag_o)
				| (timeout_irq_en_i & timeout_flag_o)
				| (tx_empty_irq_en_i & tx_empty_flag_o)
				| (tx_complete_irq_en_i & tx_complete_flag_o)
				| (cts_irq_en_i & cts_change_flag_o);
		end
	end
endmodule // usart_aux

// [testbench/tb_usart_aux.sv]
/*
 * bench for usart_aux: dma, de timing, cts stall, sync clock, mute, rx flags.
 * assumes the peer model and the bound checker.
 */
module tb_usart_aux;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0, arst_n_i = 0, baud_tick_i = 0, tx_wvalid_i = 0, rx_byte_valid_i = 0, pause = 0, talk = 0;
	logic [7:0] tx_wdata_i = 8'h00, rx_byte_i = 8'h00, b;
	logic [4:0] de_lead_time_i = 5'h02, de_lag_time_i = 5'h03;
	logic [3:0] node_address_i = 4'h5;
	logic rx_parity_err_i = 0, rx_noise_err_i = 0, rx_frame_err_i = 0, rx_char_match_i = 0, rx_timeout_i = 0;
	logic rx_data_read_i = 0, tx_send_break_i = 0, mute_request_set_i = 0, mute_request_clr_i = 0;
	logic wake_method_select_i = 0, half_duplex_enable_i = 0, clock_output_enable_i = 0, clock_polarity_i = 0;
	logic last_bit_clock_pulse_enable_i = 0, clock_phase_i = 0, cts_flow_enable_i = 0, rts_flow_enable_i = 0;
	logic driver_enable_function_i = 0, dma_transmit_enable_i = 0, dma_receive_enable_i = 0, flag_clr_i = 0;
	logic rx_not_empty_irq_en_i = 0, idle_irq_en_i = 0, parity_irq_en_i = 0, error_irq_en_i = 0;
	logic char_match_irq_en_i = 0, timeout_irq_en_i = 0, tx_empty_irq_en_i = 0, tx_complete_irq_en_i = 0;
	logic cts_irq_en_i = 0, sprev = 0;
	wire rx_pin_i, cts_n_pin_i, tx_wready_o, tx_pin_o, sync_clock_out_o, rts_n_o, de_o, dma_tx_req_o, dma_rx_req_o;
	wire mute_request_o, rx_not_empty_flag_o, overrun_flag_o, idle_line_flag_o, parity_error_flag_o, irq_o, pv;
	wire noise_error_flag_o, framing_error_flag_o, char_match_flag_o, timeout_flag_o, tx_empty_flag_o;
	wire tx_complete_flag_o, cts_change_flag_o;
	wire [7:0] pb;
	int fails = 0, n_checks = 0, cyc = 0, dt = 0, pc = 0, m0, i;
	logic [7:0] q[$];

	usart_aux usart_aux_i (.*);
	usart_peer usart_peer_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .baud_tick_i(baud_tick_i), .tx_pin_i(tx_pin_o),
		.pause_i(pause), .talk_i(talk), .cts_n_o(cts_n_pin_i), .rx_pin_o(rx_pin_i), .byte_o(pb), .byte_v_o(pv));

	// ----------------------------------------------------------------
	// clock, bit tick every 8 cycles, watchers and hang limit
	// ----------------------------------------------------------------
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		baud_tick_i <= (cyc % 8 == 7);
		sprev <= sync_clock_out_o;
		if (baud_tick_i && de_o && tx_pin_o)
			dt <= dt + 1;
		if (sync_clock_out_o !== sprev && sync_clock_out_o === !clock_polarity_i)
			pc <= pc + 1;
		if (cyc == 20000)
		begin
			fails++;
			results;
		end
	end

	task chk(input logic [7:0] g, e, input string m);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task wt(input int k);
		repeat (k) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask
	// writes only when ready, then lets the late ready catch up
	task put(input logic [7:0] d);
		for (i = 0; i < 2000 && tx_wready_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		if (tx_wready_o !== 1'b1)
			fails++;
		@(posedge clk_sys_i);
		tx_wdata_i <= d;
		tx_wvalid_i <= 1;
		@(posedge clk_sys_i);
		tx_wvalid_i <= 0;
		wt(1);
	endtask
	task getb;
		for (i = 0; i < 3000 && pv !== 1'b1; i++)
			@(negedge clk_sys_i);
		if (pv !== 1'b1)
			fails++;
		b = pb;
		@(negedge clk_sys_i);
	endtask
	task rxb(input logic [7:0] d);
		@(posedge clk_sys_i);
		rx_byte_i <= d;
		rx_byte_valid_i <= 1;
		@(posedge clk_sys_i);
		rx_byte_valid_i <= 0;
		wt(0);
	endtask
	task results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		wt(16);
		arst_n_i <= 1;
		wt(2);
		chk({de_o, irq_o, tx_empty_flag_o, tx_complete_flag_o}, 8'h03, "reset");
		tx_empty_irq_en_i <= 1;
		wt(3);
		chk(irq_o, 1, "irq on");
		tx_empty_irq_en_i <= 0;
		flag_clr_i <= 1; // complete flag cleared before dma use
		wt(0);
		flag_clr_i <= 0;
		dma_transmit_enable_i <= 1;
		wt(3);
		chk({irq_o, tx_complete_flag_o, dma_tx_req_o}, 8'h01, "dma request");
		put(8'h5a);
		dma_transmit_enable_i <= 0;
		getb;
		chk(b, 8'h5a, "dma byte");
		wt(20);
		chk(tx_complete_flag_o, 1, "complete");
		$display("test dma done");
		driver_enable_function_i <= 1;
		wt(2);
		m0 = dt;
		put(8'ha5);
		for (i = 0; i < 500 && tx_pin_o !== 1'b0; i++)
			@(negedge clk_sys_i);
		chk(dt - m0, 8'h02, "de lead");
		getb;
		m0 = dt;
		chk(b, 8'ha5, "de byte");
		for (i = 0; i < 500 && de_o !== 1'b0; i++)
			@(negedge clk_sys_i);
		chk(dt - m0, 8'h03, "de lag");
		driver_enable_function_i <= 0;
		$display("test de done");
		cts_flow_enable_i <= 1;
		pause <= 1;
		wt(5);
		for (m0 = 0; m0 < 5; m0++)
			if (tx_wready_o === 1'b1)
			begin
				put(8'hc0 + m0[7:0]);
				q.push_back(8'hc0 + m0[7:0]);
			end
		wt(240);
		chk({tx_pin_o, tx_wready_o}, 8'h02, "stalled full");
		pause <= 0;
		for (i = 0; i < 500 && tx_pin_o !== 1'b0; i++)
			@(negedge clk_sys_i);
		wt(24);
		pause <= 1;
		getb;
		chk(b, q.pop_front(), "last before stall");
		wt(200);
		chk(tx_pin_o, 1, "held");
		pause <= 0;
		while (q.size() > 0)
		begin
			getb;
			chk(b, q.pop_front(), "after stall");
		end
		$display("test cts done");
		clock_output_enable_i <= 1; // half duplex stays clear
		clock_polarity_i <= 1;
		for (m0 = 0; m0 < 2; m0++)
		begin
			last_bit_clock_pulse_enable_i <= m0[0];
			clock_phase_i <= m0[0];
			wt(30);
			m0 = m0 + 8 * pc;
			put(8'h3c);
			getb;
			chk(b, 8'h3c, "sync byte");
			wt(16);
			chk(pc - m0 / 8, 8'h07 + m0[7:0] % 8, "pulses");
			m0 = m0 % 8;
		end
		tx_send_break_i <= 1;
		for (i = 0; i < 500 && tx_pin_o !== 1'b0; i++)
			@(negedge clk_sys_i);
		tx_send_break_i <= 0;
		wt(200);
		chk({tx_pin_o, sync_clock_out_o}, 8'h03, "after break");
		clock_output_enable_i <= 0;
		$display("test sync done");
		{dma_receive_enable_i, rts_flow_enable_i, rx_not_empty_irq_en_i} <= 3'h7;
		rxb(8'h11);
		chk({rx_not_empty_flag_o, rts_n_o, dma_rx_req_o}, 8'h07, "rx flags");
		wt(0);
		chk({irq_o, dma_rx_req_o, rx_not_empty_flag_o}, 8'h04, "rx irq, dma read");
		rx_data_read_i <= 1;
		wt(0);
		rx_data_read_i <= 0;
		flag_clr_i <= 1;
		wt(0);
		flag_clr_i <= 0;
		mute_request_set_i <= 1;
		wt(0);
		mute_request_set_i <= 0;
		wt(2);
		chk({rts_n_o, mute_request_o}, 8'h01, "muted");
		rxb(8'h22);
		chk(rx_not_empty_flag_o, 0, "muted byte");
		talk <= 1;
		wt(24);
		talk <= 0;
		wt(60);
		chk(mute_request_o, 1, "short idle");
		wt(50);
		chk(mute_request_o, 0, "idle wake");
		mute_request_set_i <= 1;
		wt(0);
		mute_request_set_i <= 0;
		mute_request_clr_i <= 1;
		wt(0);
		mute_request_clr_i <= 0;
		wt(2);
		chk(mute_request_o, 0, "sw clear");
		wake_method_select_i <= 1;
		rxb(8'h83);
		chk(mute_request_o, 1, "addr miss");
		rxb(8'hf5);
		chk(mute_request_o, 0, "addr hit");
		rxb(8'h17);
		chk(rx_not_empty_flag_o, 1, "data after hit");
		rxb(8'h8a);
		chk(mute_request_o, 1, "remute");
		$display("test mute done");
		results;
	end
endmodule // tb_usart_aux

bind usart_aux usart_aux_sva usart_aux_sva_i (.*);

// [testbench/usart_aux_sva.sv]
/*
 * assertions for usart_aux: mute, rx flags, dma, sync clock idle, flow, irq.
 * assumes it is bound to usart_aux and sees only its ports.
 */
module usart_aux_sva
(
	input wire clk_sys_i, arst_n_i, baud_tick_i, // clock, reset, bit tick
	input wire [7:0] rx_byte_i, // received byte
	input wire [3:0] node_address_i, // own address
	input wire rx_byte_valid_i, wake_method_select_i, mute_request_set_i, mute_request_clr_i, // rx side
	input wire clock_polarity_i, cts_n_pin_i, cts_flow_enable_i, rts_flow_enable_i, dma_receive_enable_i, // config
	input wire rx_not_empty_irq_en_i, idle_irq_en_i, parity_irq_en_i, error_irq_en_i, char_match_irq_en_i, // enables
	input wire timeout_irq_en_i, tx_empty_irq_en_i, tx_complete_irq_en_i, cts_irq_en_i, // enables
	input wire tx_pin_o, sync_clock_out_o, rts_n_o, dma_rx_req_o, mute_request_o, irq_o, // outputs
	input wire rx_not_empty_flag_o, overrun_flag_o, idle_line_flag_o, parity_error_flag_o, noise_error_flag_o, // flags
	input wire framing_error_flag_o, char_match_flag_o, timeout_flag_o, tx_empty_flag_o, tx_complete_flag_o, // flags
	input wire cts_change_flag_o // flag
);
	reg [3:0] run_ff;
	reg last_ff;
	wire plain = rx_byte_valid_i && !mute_request_o && !(wake_method_select_i && rx_byte_i[7]);
	wire adr_miss = rx_byte_i[3:0] != node_address_i;
	wire irq_src = (rx_not_empty_irq_en_i & (rx_not_empty_flag_o | overrun_flag_o)) | (idle_irq_en_i & idle_line_flag_o)
		| (parity_irq_en_i & parity_error_flag_o) | (char_match_irq_en_i & char_match_flag_o)
		| (error_irq_en_i & dma_receive_enable_i & (noise_error_flag_o | overrun_flag_o | framing_error_flag_o))
		| (timeout_irq_en_i & timeout_flag_o) | (tx_empty_irq_en_i & tx_empty_flag_o)
		| (tx_complete_irq_en_i & tx_complete_flag_o) | (cts_irq_en_i & cts_change_flag_o);

	// ----------------------------------------------------------------
	// ticks since the tx line last changed; ten or more means idle or break
	// ----------------------------------------------------------------
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			run_ff <= 4'h0;
			last_ff <= 1'b1;
		end
		else
		begin
			last_ff <= tx_pin_o;
			if (tx_pin_o != last_ff)
				run_ff <= 4'h0;
			else if (baud_tick_i && run_ff != 4'hf)
				run_ff <= run_ff + 4'h1;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	chk_mute_quiet: assert property (mute_request_o && rx_byte_valid_i |=> !dma_rx_req_o)
		else $error("muted byte raised a dma request");
	chk_rx_dma_pulse: assert property (plain && dma_receive_enable_i |=>
		dma_rx_req_o && rx_not_empty_flag_o ##1 !dma_rx_req_o)
		else $error("rx dma request not a single pulse");
	chk_addr_wake: assert property (wake_method_select_i && rx_byte_valid_i && rx_byte_i[7] |=>
		mute_request_o == $past(adr_miss))
		else $error("mute state does not follow address compare");
	chk_sw_unmute: assert property (mute_request_clr_i && !mute_request_set_i && !rx_byte_valid_i |=>
		!mute_request_o)
		else $error("software clear left mute on");
	chk_clock_idle: assert property (run_ff >= 4'ha && $stable(clock_polarity_i) |->
		sync_clock_out_o == clock_polarity_i)
		else $error("sync clock active while line idle or break");
	chk_rts_pause: assert property (rts_flow_enable_i && plain |-> ##[1:2] rts_n_o)
		else $error("rts not raised after a received byte");
	chk_irq_merge: assert property (irq_o == $past(irq_src))
		else $error("irq output differs from enabled sources");
	// cts passes two sync stages, so the start decision sees the pin two edges old
	chk_cts_hold: assert property (cts_flow_enable_i && $past(cts_n_pin_i, 2) && run_ff >= 4'ha && tx_pin_o |=> tx_pin_o)
		else $error("frame started while cts high");

	cover property (plain && dma_receive_enable_i);
	cover property (run_ff >= 4'ha && !tx_pin_o);
	cover property ($fell(mute_request_o));
endmodule // usart_aux_sva

// [testbench/usart_peer.sv]
/*
 * peer transceiver model: decodes the tx line, drives cts and rx line.
 * assumes bits change one cycle after a baud tick, lsb first.
 */
module usart_peer
(
	input wire clk_sys_i, // clock
	input wire arst_n_i, // reset, low
	input wire baud_tick_i, // bit time pulse
	input wire tx_pin_i, // line from device
	input wire pause_i, // bench asks peer to stall
	input wire talk_i, // bench asks peer to hold rx low
	output wire cts_n_o, // clear to send, low
	output wire rx_pin_o, // line to device
	output reg [7:0] byte_o, // last decoded byte
	output reg byte_v_o // decoded byte pulse
);
	reg [3:0] cnt_ff;
	reg [7:0] sh_ff;
	assign cts_n_o = pause_i;
	assign rx_pin_o = !talk_i;

	// sample each bit at the tick closing it; a low stop drops the byte
	always @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_ff <= 4'h0;
			byte_v_o <= 1'b0;
		end
		else
		begin
			byte_v_o <= 1'b0;
			if (baud_tick_i && cnt_ff == 4'h0)
				cnt_ff <= {3'h0, !tx_pin_i};
			else if (baud_tick_i && cnt_ff == 4'h9)
			begin
				cnt_ff <= 4'h0;
				byte_o <= sh_ff;
				byte_v_o <= tx_pin_i;
			end
			else if (baud_tick_i)
			begin
				sh_ff <= {tx_pin_i, sh_ff[7:1]};
				cnt_ff <= cnt_ff + 4'h1;
			end
		end
	end
endmodule // usart_peer
